//--- logic/cpu_flags_interrupt_entry.sv
// cpu register file, flags word and hardware interrupt entry / return sequencer
// assumes a byte memory whose read data is valid the cycle after mem_re_o,
// and a datapath that signals instruction completion with instr_done_i
`include "cpu_core_map.svh"
module cpu_flags_interrupt_entry #(
  parameter int          NVEC   = 16,
  parameter logic [15:0] SP_TOP = `SP_TOP
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   instr_done_i,
  input  wire logic                   return_from_service_i,
  input  wire logic [NVEC-1:0]        irq_i,
  input  wire logic [2*NVEC-1:0]      vector_priority_fields_i,
  input  wire logic                   add_go_i,
  input  wire logic                   add_carry_in_i,
  input  wire logic [7:0]             operand_i,
  input  wire logic                   result_we_i,
  input  wire logic [7:0]             result_i,
  input  wire logic                   carry_we_i,
  input  wire logic                   carry_val_i,
  input  wire logic                   x_we_i,
  input  wire logic                   y_we_i,
  input  wire logic [7:0]             index_wdata_i,
  input  wire logic                   pc_we_i,
  input  wire logic [15:0]            pc_wdata_i,
  input  wire logic                   sp_we_i,
  input  wire logic [15:0]            sp_wdata_i,
  input  wire logic                   prio_we_i,
  input  wire cpu_core_pkg::prio_code_t prio_wdata_i,
  input  wire logic                   flags_we_i,
  input  wire logic [7:0]             flags_wdata_i,
  input  wire logic [7:0]             mem_rdata_i,
  output logic [7:0]                  a_o,
  output logic [7:0]                  x_o,
  output logic [7:0]                  y_o,
  output logic [15:0]                 pc_o,
  output logic [15:0]                 sp_o,
  output logic [7:0]                  flags_word_o,
  output logic                        busy_o,
  output logic                        ack_o,
  output logic [3:0]                  ack_vec_o,
  output logic [15:0]                 mem_addr_o,
  output logic [7:0]                  mem_wdata_o,
  output logic                        mem_we_o,
  output logic                        mem_re_o
);
  import cpu_core_pkg::*;

  initial begin
    if (NVEC < 3 || NVEC > 16) $error("NVEC must lie in 3..16");
  end

  // level number from the two priority bits (bit5, bit3)
  function automatic logic [1:0] lvl_of(input prio_code_t c);
    case (c)
      2'h2:    lvl_of = 2'h0;
      2'h1:    lvl_of = 2'h1;
      2'h0:    lvl_of = 2'h2;
      default: lvl_of = 2'h3;
    endcase
  endfunction

  logic [7:0]  a_r, a_nxt, x_r, x_nxt, y_r, y_nxt, cc_r, cc_nxt, wd_r, wd_nxt;
  logic [15:0] pc_r, pc_nxt, sp_r, sp_nxt, ad_r, ad_nxt, vec_r, vec_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [3:0]  av_r, av_nxt;
  logic        we_r, we_nxt, re_r, re_nxt, ack_r, ack_nxt, busy_r, busy_nxt;
  prio_code_t  np_r, np_nxt;
  seq_state_t  seq_r, seq_nxt;

  // arbitration: highest programmed level first, lowest index on ties
  logic        take;
  logic [3:0]  win;
  prio_code_t  win_code;
  logic [1:0]  best;
  always_comb begin
    take     = 1'b0;
    win      = 4'h0;
    win_code = `PRIO_LEVEL3;
    best     = 2'h0;
    for (int k = NVEC - 1; k >= 1; k--) begin
      if (irq_i[k]) begin
        if (k == `NMI_TRAP_IDX || k == `NMI_TOP_IDX) begin
          take     = 1'b1;
          win      = 4'(k);
          win_code = `PRIO_LEVEL3;
          best     = 2'h3;
        end else if (lvl_of(vector_priority_fields_i[2*k +: 2]) >
                     lvl_of({cc_r[`CC_BIT_PHI], cc_r[`CC_BIT_PLO]}) &&
                     (!take || lvl_of(vector_priority_fields_i[2*k +: 2]) >= best)) begin
          take     = 1'b1;
          win      = 4'(k);
          win_code = vector_priority_fields_i[2*k +: 2];
          best     = lvl_of(win_code);
        end
      end
    end
  end

  // byte pushed at each step of entry
  function automatic logic [7:0] push_byte(input logic [2:0] n, input logic [15:0] pc,
                                           input logic [7:0] x, input logic [7:0] a,
                                           input logic [7:0] cc);
    case (n)
      3'h0:    push_byte = pc[7:0];
      3'h1:    push_byte = pc[15:8];
      3'h2:    push_byte = x;
      3'h3:    push_byte = a;
      default: push_byte = cc;
    endcase
  endfunction

  // adder for add and add-with-carry
  logic [4:0] lo_sum;
  logic [8:0] sum;
  always_comb begin
    lo_sum = {1'b0, a_r[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, add_carry_in_i & cc_r[0]};
    sum    = {1'b0, a_r} + {1'b0, operand_i} + {8'h00, add_carry_in_i & cc_r[0]};
  end

  // next-state for registers, flags and the entry/return sequencer
  always_comb begin
    a_nxt = a_r;  x_nxt = x_r;  y_nxt = y_r;  cc_nxt = cc_r;
    pc_nxt = pc_r; sp_nxt = sp_r; vec_nxt = vec_r; np_nxt = np_r;
    cnt_nxt = cnt_r; av_nxt = av_r; seq_nxt = seq_r;
    ad_nxt = ad_r; wd_nxt = wd_r;
    we_nxt = 1'b0; re_nxt = 1'b0; ack_nxt = 1'b0;
    case (seq_r)
      S_RST: begin
        ad_nxt = `VEC_TOP;
        vec_nxt = `VEC_TOP;
        re_nxt = 1'b1;
        seq_nxt = S_VH;
      end
      S_RUN: begin
        // datapath writes, only between sequences
        if (add_go_i) begin
          a_nxt = sum[7:0];
          cc_nxt[`CC_BIT_H] = lo_sum[4];
          cc_nxt[`CC_BIT_C] = sum[8];
          cc_nxt[`CC_BIT_N] = sum[7];
          cc_nxt[`CC_BIT_Z] = (sum[7:0] == 8'h00);
        end else if (result_we_i) begin
          a_nxt = result_i;
          cc_nxt[`CC_BIT_N] = result_i[7];
          cc_nxt[`CC_BIT_Z] = (result_i == 8'h00);
        end
        if (carry_we_i) cc_nxt[`CC_BIT_C] = carry_val_i;
        if (prio_we_i) begin
          cc_nxt[`CC_BIT_PHI] = prio_wdata_i[1];
          cc_nxt[`CC_BIT_PLO] = prio_wdata_i[0];
        end
        if (flags_we_i) cc_nxt = flags_wdata_i;
        if (x_we_i) x_nxt = index_wdata_i;
        if (y_we_i) y_nxt = index_wdata_i;
        if (pc_we_i) pc_nxt = pc_wdata_i;
        if (sp_we_i) sp_nxt = sp_wdata_i;
        // sequences start only at an instruction boundary
        if (instr_done_i && return_from_service_i) begin
          sp_nxt  = sp_r + 16'h0001;
          ad_nxt  = sp_r + 16'h0001;
          re_nxt  = 1'b1;
          cnt_nxt = 3'h0;
          seq_nxt = S_POP;
        end else if (instr_done_i && take) begin
          np_nxt  = win_code;
          vec_nxt = `VEC_TOP - {11'h000, win, 1'b0};
          ack_nxt = 1'b1;
          av_nxt  = win;
          ad_nxt  = sp_r;
          wd_nxt  = push_byte(3'h0, pc_nxt, x_nxt, a_nxt, cc_nxt);
          sp_nxt  = sp_r - 16'h0001;
          we_nxt  = 1'b1;
          cnt_nxt = 3'h0;
          seq_nxt = S_PUSH;
        end
      end
      S_PUSH: begin
        if (cnt_r != `PUSH_LAST) begin
          cnt_nxt = cnt_r + 3'h1;
          ad_nxt  = sp_r;
          wd_nxt  = push_byte(cnt_nxt, pc_r, x_r, a_r, cc_r);
          sp_nxt  = sp_r - 16'h0001;
          we_nxt  = 1'b1;
        end else begin
          // level changes only after the old flags word is stacked
          cc_nxt[`CC_BIT_PHI] = np_r[1];
          cc_nxt[`CC_BIT_PLO] = np_r[0];
          ad_nxt = vec_r;
          re_nxt = 1'b1;
          seq_nxt = S_VH;
        end
      end
      S_VH: begin
        ad_nxt = vec_r + 16'h0001;
        re_nxt = 1'b1;
        seq_nxt = S_VL;
      end
      S_VL: begin
        pc_nxt[15:8] = mem_rdata_i;
        seq_nxt = S_VD;
      end
      S_VD: begin
        pc_nxt[7:0] = mem_rdata_i;
        seq_nxt = S_RUN;
      end
      S_POP: begin
        // capture previous byte: flags, accumulator, index, pc high
        case (cnt_r)
          3'h1:    cc_nxt = mem_rdata_i;
          3'h2:    a_nxt = mem_rdata_i;
          3'h3:    x_nxt = mem_rdata_i;
          3'h4:    pc_nxt[15:8] = mem_rdata_i;
          default: ;
        endcase
        if (cnt_r != `PUSH_LAST) begin
          cnt_nxt = cnt_r + 3'h1;
          sp_nxt  = sp_r + 16'h0001;
          ad_nxt  = sp_r + 16'h0001;
          re_nxt  = 1'b1;
        end else begin
          seq_nxt = S_POPD;
        end
      end
      S_POPD: begin
        pc_nxt[7:0] = mem_rdata_i;
        seq_nxt = S_RUN;
      end
      default: seq_nxt = S_RST;
    endcase
    busy_nxt = (seq_nxt != S_RUN);
  end

  // register stage; y is never loaded by a sequence
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      a_r <= 8'h00; x_r <= 8'h00; y_r <= 8'h00;
      cc_r <= `CC_RESET;
      pc_r <= 16'h0000;
      sp_r <= SP_TOP;
      vec_r <= `VEC_TOP; np_r <= `PRIO_LEVEL3;
      cnt_r <= 3'h0; av_r <= 4'h0; seq_r <= S_RST;
      ad_r <= 16'h0000; wd_r <= 8'h00;
      we_r <= 1'b0; re_r <= 1'b0; ack_r <= 1'b0; busy_r <= 1'b1;
    end else begin
      a_r <= a_nxt; x_r <= x_nxt; y_r <= y_nxt;
      cc_r <= cc_nxt; pc_r <= pc_nxt; sp_r <= sp_nxt;
      vec_r <= vec_nxt; np_r <= np_nxt;
      cnt_r <= cnt_nxt; av_r <= av_nxt; seq_r <= seq_nxt;
      ad_r <= ad_nxt; wd_r <= wd_nxt;
      we_r <= we_nxt; re_r <= re_nxt; ack_r <= ack_nxt; busy_r <= busy_nxt;
    end
  end

  assign a_o = a_r;
  assign x_o = x_r;
  assign y_o = y_r;
  assign pc_o = pc_r;
  assign sp_o = sp_r;
  assign flags_word_o = cc_r;
  assign busy_o = busy_r;
  assign ack_o = ack_r;
  assign ack_vec_o = av_r;
  assign mem_addr_o = ad_r;
  assign mem_wdata_o = wd_r;
  assign mem_we_o = we_r;
  assign mem_re_o = re_r;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_entry;
    seq_r == S_RUN && instr_done_i && !return_from_service_i && take;
  endsequence
  sequence s_stack5;
    we_r [*5] ##1 re_r;
  endsequence

  property p_cc_reset;
    $past(reset_i) && seq_r == S_RST |-> cc_r == `CC_RESET;
  endproperty
  a_cc_reset: assert property (p_cc_reset) else $error("flags reset value wrong");
  property p_vec_load;
    seq_r == S_VD |=> pc_r == {$past(mem_rdata_i, 2), $past(mem_rdata_i)};
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("vector not loaded");
  property p_y_hold;
    seq_r != S_RUN |=> $stable(y_r);
  endproperty
  a_y_hold: assert property (p_y_hold) else $error("y changed by sequence");
  property p_half;
    seq_r == S_RUN && add_go_i && !flags_we_i && a_r[3:0] == 4'hF && operand_i[3:0] == 4'h1
      |=> cc_r[`CC_BIT_H];
  endproperty
  a_half: assert property (p_half) else $error("half carry missed");
  property p_nz;
    seq_r == S_RUN && result_we_i && !add_go_i && !flags_we_i
      |=> cc_r[`CC_BIT_N] == a_r[7] && cc_r[`CC_BIT_Z] == (a_r == 8'h00);
  endproperty
  a_nz: assert property (p_nz) else $error("sign or zero flag wrong");
  property p_stack;
    s_entry |=> s_stack5;
  endproperty
  a_stack: assert property (p_stack) else $error("entry stacking wrong");
  property p_prio_load;
    seq_r == S_PUSH && cnt_r == `PUSH_LAST |=> {cc_r[`CC_BIT_PHI], cc_r[`CC_BIT_PLO]} == np_r;
  endproperty
  a_prio_load: assert property (p_prio_load) else $error("level not loaded");
  property p_pop_cc;
    seq_r == S_POP && cnt_r == 3'h1 |=> cc_r == $past(mem_rdata_i);
  endproperty
  a_pop_cc: assert property (p_pop_cc) else $error("flags not restored");
  property p_boundary;
    ack_r |-> $past(instr_done_i) && $past(seq_r) == S_RUN;
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry mid instruction");
  property p_nmi;
    seq_r == S_RUN && instr_done_i && !return_from_service_i && irq_i[`NMI_TRAP_IDX] |=> ack_r;
  endproperty
  a_nmi: assert property (p_nmi) else $error("trap was masked");
endmodule

//--- logic/cpu_core_map.svh
// fixed addresses, field positions, reset values for the cpu core state block
// assumes 16-bit addresses and 8-bit data
`ifndef CPU_CORE_MAP_SVH
`define CPU_CORE_MAP_SVH
`define CC_RESET      8'hE8
`define CC_BIT_C      0
`define CC_BIT_Z      1
`define CC_BIT_N      2
`define CC_BIT_PLO    3
`define CC_BIT_H      4
`define CC_BIT_PHI    5
`define VEC_TOP       16'hFFFE
`define VEC_BASE      16'hFFE0
`define SP_TOP        16'h01FF
`define PRIO_LEVEL3   2'h3
`define PUSH_LAST     3'h4
`define NMI_TRAP_IDX  1
`define NMI_TOP_IDX   2
`endif

//--- logic/cpu_core_pkg.sv
// types shared by the cpu core state block
// assumes nothing beyond the map header
package cpu_core_pkg;
  typedef enum logic [2:0] {S_RST, S_RUN, S_PUSH, S_VH, S_VL, S_VD, S_POP, S_POPD} seq_state_t;
  typedef logic [1:0] prio_code_t;
endpackage

//--- verification/cpu_mem_model.sv
// byte memory with the vector table, far side of the core state block
// assumes read data is wanted the cycle after a read strobe
module cpu_mem_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  input  wire logic        mem_we_i,
  input  wire logic        mem_re_i,
  output logic      [7:0]  mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  // vector k sits at FFFE-2k, high byte at the lower address
  initial begin
    mem_rdata_o = 8'h00;
    for (int k = 0; k < 16; k++) begin
      mem[16'hFFFE - 2 * k] = 8'hC0 + 8'(k);
      mem[16'hFFFF - 2 * k] = 8'(4 * k);
    end
  end
  // idle cycles toggle the bus so stale data never passes for a read
  always @(posedge clk_i) begin
    if (mem_we_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
    mem_rdata_o <= mem_re_i ? mem[mem_addr_i] : ~mem_rdata_o;
  end
endmodule

//--- verification/test_cpu_flags_interrupt_entry.sv
// self-checking bench for the core state and interrupt entry block
// assumes the memory model above answers every read the next cycle
module test_cpu_flags_interrupt_entry;
  timeunit 1ns;
  timeprecision 1ns;
  import cpu_core_pkg::*;
  logic        clk_i, reset_i, instr_done_i, return_from_service_i, add_go_i, add_carry_in_i;
  logic        result_we_i, carry_we_i, carry_val_i, x_we_i, y_we_i, pc_we_i, sp_we_i;
  logic        prio_we_i, flags_we_i, busy_o, ack_o, mem_we_o, mem_re_o;
  logic [15:0] irq_i, pc_wdata_i, sp_wdata_i, pc_o, sp_o, mem_addr_o, pc_m, sp_m;
  logic [31:0] vector_priority_fields_i, seed, r;
  logic [7:0]  operand_i, result_i, index_wdata_i, flags_wdata_i, mem_rdata_i, mem_wdata_o;
  logic [7:0]  a_o, x_o, y_o, flags_word_o, a_m, x_m, y_m, cc_m;
  logic [8:0]  s;
  logic [3:0]  ack_vec_o;
  prio_code_t  prio_wdata_i;
  logic [39:0] ctx_q [$];
  int          n_errors, checks;

  cpu_flags_interrupt_entry cpu_flags_interrupt_entry_inst (.clk_i, .reset_i, .instr_done_i,
    .return_from_service_i, .irq_i, .vector_priority_fields_i, .add_go_i, .add_carry_in_i,
    .operand_i, .result_we_i, .result_i, .carry_we_i, .carry_val_i, .x_we_i, .y_we_i,
    .index_wdata_i, .pc_we_i, .pc_wdata_i, .sp_we_i, .sp_wdata_i, .prio_we_i, .prio_wdata_i,
    .flags_we_i, .flags_wdata_i, .mem_rdata_i, .a_o, .x_o, .y_o, .pc_o, .sp_o, .flags_word_o,
    .busy_o, .ack_o, .ack_vec_o, .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o);
  cpu_mem_model cpu_mem_model_inst (.clk_i, .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_we_i(mem_we_o), .mem_re_i(mem_re_o), .mem_rdata_o(mem_rdata_i));

  // xorshift keeps the run repeatable
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] vec(input int k);
    return {8'hC0 + 8'(k), 8'(4 * k)};
  endfunction
  task chk(input string name, input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask
  task step;
    @(negedge clk_i);
  endtask
  task regs;
    chk("a", a_o, a_m);
    chk("x", x_o, x_m);
    chk("y", y_o, y_m);
    chk("pc", pc_o, pc_m);
    chk("sp", sp_o, sp_m);
    chk("flags", flags_word_o, cc_m);
  endtask
  // bounded wait; a hang shows up as a busy mismatch
  task wait_idle;
    for (int i = 0; i < 40 && busy_o !== 1'b0; i++) begin
      step;
    end
    chk("busy", busy_o, 0);
  endtask
  task done_pulse(input logic ret);
    return_from_service_i = ret;
    instr_done_i = 1'b1;
    step;
    instr_done_i = 1'b0;
    return_from_service_i = 1'b0;
  endtask
  task entry(input int k, input prio_code_t code);
    logic [39:0] b;
    irq_i[k] = 1'b1;
    done_pulse(1'b0);
    chk("ack", ack_o, 1);
    chk("ack_vec", ack_vec_o, 4'(k));
    irq_i[k] = 1'b0;
    ctx_q.push_back({pc_m, x_m, a_m, cc_m});
    b = {pc_m[7:0], pc_m[15:8], x_m, a_m, cc_m};
    wait_idle;
    for (int j = 0; j < 5; j++) begin
      chk("stack", cpu_mem_model_inst.mem[16'(sp_m - j)], b[39 - 8 * j -: 8]);
    end
    sp_m -= 16'h0005;
    pc_m = vec(k);
    cc_m[5] = code[1];
    cc_m[3] = code[0];
    regs;
  endtask
  task ret;
    done_pulse(1'b1);
    wait_idle;
    {pc_m, x_m, a_m, cc_m} = ctx_q.pop_back();
    sp_m += 16'h0005;
    regs;
  endtask
  task refused;
    done_pulse(1'b0);
    chk("ack", ack_o, 0);
    chk("busy", busy_o, 0);
  endtask
  task set_prio(input prio_code_t c);
    prio_wdata_i = c;
    prio_we_i = 1'b1;
    step;
    prio_we_i = 1'b0;
    {cc_m[5], cc_m[3]} = c;
    regs;
  endtask
  task results;
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_i);
    n_errors++;
    results;
  end
  initial begin
    {instr_done_i, return_from_service_i, add_go_i, add_carry_in_i, result_we_i} = '0;
    {carry_we_i, carry_val_i, x_we_i, y_we_i, pc_we_i, sp_we_i, prio_we_i, flags_we_i} = '0;
    {irq_i, operand_i, result_i, index_wdata_i, flags_wdata_i, pc_wdata_i, sp_wdata_i} = '0;
    prio_wdata_i = 2'h0;
    vector_priority_fields_i = 32'h0000_0500; // vectors 4 and 5 at level 1
    seed = 32'd53942;
    n_errors = 0;
    checks = 0;
    {a_m, x_m, y_m, cc_m, sp_m, pc_m} = {8'h00, 8'h00, 8'h00, 8'hE8, 16'h01FF, vec(0)};
    reset_i = 1'b1;
    repeat (4) step;
    reset_i = 1'b0;
    step;
    wait_idle;
    regs;
    {index_wdata_i, pc_wdata_i} = 24'(rnd());
    {x_we_i, pc_we_i} = 2'b11;
    step;
    {x_we_i, pc_we_i} = 2'b00;
    {x_m, pc_m} = {index_wdata_i, pc_wdata_i};
    index_wdata_i = 8'(rnd());
    y_we_i = 1'b1;
    step;
    y_we_i = 1'b0;
    y_m = index_wdata_i;
    // mixed arithmetic traffic; first two passes force zero results
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      if (i < 2) r[2:0] = 3'(2 * i);
      operand_i = (i == 0) ? -a_m : r[15:8];
      result_i = (i == 1) ? 8'h00 : r[23:16];
      {carry_val_i, flags_wdata_i, add_carry_in_i} = {r[8], r[31:24], r[0]};
      case (r[2:0])
        3'h0, 3'h1: begin
          add_go_i = 1'b1;
          s = a_m + operand_i + 9'(add_carry_in_i & cc_m[0]);
          cc_m[4] = (a_m[3:0] + operand_i[3:0] + 5'(add_carry_in_i & cc_m[0])) > 5'h0F;
          {cc_m[0], a_m} = s;
        end
        3'h2: begin
          result_we_i = 1'b1;
          a_m = result_i;
        end
        3'h3: begin
          carry_we_i = 1'b1;
          cc_m[0] = carry_val_i;
        end
        default: begin
          flags_we_i = 1'b1;
          cc_m = flags_wdata_i;
        end
      endcase
      if (r[2:0] < 3'h3) {cc_m[2], cc_m[1]} = {a_m[7], a_m == 8'h00};
      step;
      {add_go_i, result_we_i, carry_we_i, flags_we_i} = '0;
      regs;
    end
    for (int c = 0; c < 4; c++) set_prio(2'(c));
    set_prio(2'b10);
    irq_i[5] = 1'b1;
    entry(4, 2'b01);
    refused;
    set_prio(2'b11);
    refused;
    entry(2, 2'b11);
    ret;
    refused;
    ret;
    entry(5, 2'b01);
    ret;
    results;
  end
endmodule
